// ### include/fps_defines.vh
`ifndef FPS_DEFINES_VH
`define FPS_DEFINES_VH
`define FPS_CMD_DWP 8'h35
`define FPS_CMD_QWP 8'h56
`define FPS_CMD_SEFP 8'h30
`define FPS_CMD_QEFP 8'h75
`define FPS_CMD_CONFIRM 8'hd0
`define FPS_CMD_CLR_STATUS 8'h50
`define FPS_EXIT_WORD 16'hffff
`define FPS_SR_READY 7
`define FPS_SR_ERASE_FAIL 5
`define FPS_SR_PROG_FAIL 4
`define FPS_SR_LOCK_VIOL 1
`define FPS_SR_BANK_WRITE 0
`define FPS_SR_RESET 8'h80
`define FPS_PAGE_WORDS 4
`define FPS_PROG_NS 8000
`endif

// ### hw/fps_fifo.v
`timescale 1ns/10ps
// Data FIFO between the host write path and the array programmer.
module fps_fifo #(
	parameter WIDTH = 40,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	// Clock and control
	input wire core_clk,
	input wire nrst,
	input wire ce,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_q];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	always @(posedge core_clk) begin
		if (ce && push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	always @(posedge core_clk) begin
		if (!nrst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ### hw/fps_sequencer.v
`timescale 1ns/10ps
`include "fps_defines.vh"
// Operation
// - Page is four words, A1:A0 differ
// - No other-bank operations or suspend meanwhile
// - Code 75h starts; reads return status
// - After setup every write is data
// - Load phase is exactly four writes
// - Only first page word address checked
// - FFFFh outside block enters exit
// - Program, verify, reprogram automatically after load; a retry only waits and re-checks arr_ok, no new array write
// - Busy: ready 0, bank-write 1, then 0
// - Next first word restarts load phase
// - Exit to read array; record failures
// - Double word: 35h then two writes
// - Quadruple word: 56h then four writes
// - Stream: 30h, D0h, data, verify, exits
// - Setup code accepted anywhere in bank
// - Confirm accepted anywhere in block
// - Ready bit 1 idle, 0 active
// - Error bits sticky until clear or reset
// - Reset aborts programming
module fps_sequencer #(
	parameter AW = 21,
	parameter BLK_BITS = 15,
	parameter BANK_BITS = 18,
	parameter DEPTH = 32,
	parameter PROG_CYC = (`FPS_PROG_NS + 24) / 25,
	parameter MAX_TRIES = 4
) (
	// Clock, reset, enable
	input wire core_clk,
	input wire nrst,
	input wire ce,
	// Host bus
	input wire bus_we,
	input wire bus_re,
	input wire [AW-1:0] bus_addr,
	input wire [15:0] bus_data,
	output reg [15:0] rd_data,
	output reg rd_valid,
	// Array programming port
	output reg arr_we,
	output reg [AW-1:0] arr_addr,
	output reg [15:0] arr_data,
	input wire arr_ok,
	input wire [15:0] arr_rdata,
	// Status and control
	output reg [7:0] status_q,
	output reg status_mode_q,
	output reg bank_lock_q,
	input wire lock_violation_in
);
	localparam S_IDLE = 8'h01;
	localparam S_SETUP_DW = 8'h02;
	localparam S_SETUP_ST = 8'h04;
	localparam S_LOAD = 8'h08;
	localparam S_PROG = 8'h10;
	localparam S_STREAM = 8'h20;
	localparam S_VERIFY = 8'h40;
	localparam S_STDRAIN = 8'h80;
	localparam MODE_DW = 2'd0;
	localparam MODE_QW = 2'd1;
	localparam MODE_QEFP = 2'd2;
	localparam MODE_SEFP = 2'd3;

	reg [7:0] st_q;
	reg [1:0] mode_q;
	reg [AW-1:0] start_word_address_q;
	reg [AW-1:0] page_q;
	reg [AW-1:0] sp_addr_q;
	reg [2:0] cnt_q;
	reg [2:0] need_q;
	reg [15:0] wait_q;
	reg [2:0] tries_q;
	reg we_s1, we_s2, we_s3, re_s1, re_s2;
	reg [AW-1:0] a_s1, a_s2;
	reg [15:0] d_s1, d_s2;
	wire we_p;
	wire in_blk;
	wire exit_hit;
	reg f_valid;
	reg [AW+15:0] f_in;
	wire f_ready;
	wire q_valid;
	reg q_ready;
	wire [AW+15:0] q_data;

	assign we_p = we_s2 & ~we_s3;
	assign in_blk = (a_s2[AW-1:BLK_BITS] ==
		start_word_address_q[AW-1:BLK_BITS]);
	assign exit_hit = !in_blk && (d_s2 == `FPS_EXIT_WORD);

	fps_fifo #(.WIDTH(AW+16), .DEPTH(DEPTH), .AW(5)) fps_fifo_i (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_in),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	// Bus pins come from an asynchronous host: two stages first.
	always @(posedge core_clk) begin
		if (!nrst) begin
			we_s1 <= 1'b0;
			we_s2 <= 1'b0;
			we_s3 <= 1'b0;
			re_s1 <= 1'b0;
			re_s2 <= 1'b0;
			a_s1 <= {AW{1'b0}};
			a_s2 <= {AW{1'b0}};
			d_s1 <= 16'h0000;
			d_s2 <= 16'h0000;
		end else if (ce) begin
			we_s1 <= bus_we;
			we_s2 <= we_s1;
			we_s3 <= we_s2;
			re_s1 <= bus_re;
			re_s2 <= re_s1;
			a_s1 <= bus_addr;
			a_s2 <= a_s1;
			d_s1 <= bus_data;
			d_s2 <= d_s1;
		end
	end

	// Word queued for the array: load words packed by slot, stream raw.
	always @* begin
		f_valid = 1'b0;
		f_in = {a_s2, d_s2};
		if (we_p && st_q == S_LOAD) begin
			f_valid = 1'b1;
			f_in = {page_q[AW-1:2], cnt_q[1:0], d_s2};
			if (cnt_q == 3'd0) begin
				f_in = {a_s2[AW-1:2], 2'b00, d_s2};
				f_valid = (mode_q != MODE_QEFP) || in_blk;
			end
		end else if (we_p && (st_q == S_STREAM || st_q == S_VERIFY)) begin
			f_valid = !exit_hit;
		end
	end

	always @(posedge core_clk) begin
		if (!nrst) begin
			// Reset aborts any program cycle under way.
			st_q <= S_IDLE;
			mode_q <= MODE_DW;
			start_word_address_q <= {AW{1'b0}};
			page_q <= {AW{1'b0}};
			sp_addr_q <= {AW{1'b0}};
			cnt_q <= 3'd0;
			need_q <= 3'd0;
			wait_q <= 16'h0000;
			tries_q <= 3'd0;
			q_ready <= 1'b0;
			status_q <= `FPS_SR_RESET;
			status_mode_q <= 1'b0;
			bank_lock_q <= 1'b0;
			rd_data <= 16'h0000;
			rd_valid <= 1'b0;
			arr_we <= 1'b0;
			arr_addr <= {AW{1'b0}};
			arr_data <= 16'h0000;
		end else if (ce) begin
			arr_we <= 1'b0;
			q_ready <= 1'b0;
			rd_valid <= re_s2;
			rd_data <= status_mode_q ? {8'h00, status_q} : arr_rdata;
			case (st_q)
			S_IDLE: begin
				if (we_p) begin
					// Setup is taken at any address of the bank.
					start_word_address_q <= a_s2;
					cnt_q <= 3'd0;
					case (d_s2[7:0])
					`FPS_CMD_DWP: begin
						mode_q <= MODE_DW;
						need_q <= 3'd2;
						st_q <= S_LOAD;
						status_mode_q <= 1'b1;
						bank_lock_q <= 1'b1;
					end
					`FPS_CMD_QWP: begin
						mode_q <= MODE_QW;
						need_q <= 3'd4;
						st_q <= S_LOAD;
						status_mode_q <= 1'b1;
						bank_lock_q <= 1'b1;
					end
					`FPS_CMD_QEFP: begin
						mode_q <= MODE_QEFP;
						need_q <= 3'd4;
						st_q <= S_LOAD;
						status_mode_q <= 1'b1;
						bank_lock_q <= 1'b1;
					end
					`FPS_CMD_SEFP: begin
						mode_q <= MODE_SEFP;
						st_q <= S_SETUP_ST;
					end
					`FPS_CMD_CLR_STATUS: begin
						status_q <= `FPS_SR_RESET;
					end
					default: status_mode_q <= 1'b0;
					endcase
				end
			end
			S_SETUP_ST: begin
				// Confirm at any address in the block.
				if (we_p) begin
					if (d_s2[7:0] == `FPS_CMD_CONFIRM) begin
						st_q <= S_STREAM;
						status_mode_q <= 1'b1;
						bank_lock_q <= 1'b1;
						status_q[`FPS_SR_READY] <= 1'b0;
					end else begin
						st_q <= S_IDLE;
					end
				end
			end
			S_LOAD: begin
				if (we_p) begin
					if (cnt_q == 3'd0 && mode_q == MODE_QEFP && exit_hit) begin
						st_q <= S_IDLE;
						status_mode_q <= 1'b0;
						bank_lock_q <= 1'b0;
						status_q[`FPS_SR_READY] <= 1'b1;
					end else if (f_valid) begin
						status_q[`FPS_SR_READY] <= 1'b0;
						if (cnt_q == 3'd0) begin
							page_q <= a_s2;
						end
						if (cnt_q + 3'd1 == need_q) begin
							cnt_q <= 3'd0;
							st_q <= S_PROG;
							status_q[`FPS_SR_BANK_WRITE] <= 1'b1;
							wait_q <= 16'h0000;
							tries_q <= 3'd0;
						end else begin
							cnt_q <= cnt_q + 3'd1;
						end
					end
				end
			end
			S_PROG: begin
				// Words drain from the FIFO, then program and verify.
				if (q_valid && !q_ready) begin
					q_ready <= 1'b1;
					arr_we <= 1'b1;
					arr_addr <= q_data[AW+15:16];
					arr_data <= q_data[15:0];
				end else if (!q_valid) begin
					if (wait_q == PROG_CYC[15:0]) begin
						wait_q <= 16'h0000;
						if (arr_ok || tries_q == MAX_TRIES[2:0]) begin
							status_q[`FPS_SR_PROG_FAIL] <=
								status_q[`FPS_SR_PROG_FAIL] | ~arr_ok;
							status_q[`FPS_SR_BANK_WRITE] <= 1'b0;
							if (mode_q == MODE_QEFP) begin
								st_q <= S_LOAD;
							end else begin
								st_q <= S_IDLE;
								bank_lock_q <= 1'b0;
								status_q[`FPS_SR_READY] <= 1'b1;
							end
						end else begin
							tries_q <= tries_q + 3'd1;
						end
					end else begin
						wait_q <= wait_q + 16'h0001;
					end
				end
			end
			S_STREAM, S_VERIFY: begin
				status_q[`FPS_SR_BANK_WRITE] <= ~f_ready;
				if (q_valid && !q_ready) begin
					q_ready <= 1'b1;
					arr_data <= q_data[15:0];
					// A repeated start address steps to the next location.
					if (cnt_q == 3'd0 || q_data[AW+15:16] != sp_addr_q) begin
						arr_addr <= q_data[AW+15:16];
					end else begin
						arr_addr <= arr_addr + 1'b1;
					end
					if (cnt_q == 3'd0) begin
						sp_addr_q <= q_data[AW+15:16];
					end
					cnt_q <= 3'd1;
					arr_we <= (st_q == S_STREAM);
				end else if (q_ready && st_q == S_VERIFY) begin
					arr_we <= (arr_rdata != arr_data);
				end
				if (we_p && exit_hit) begin
					st_q <= (st_q == S_STREAM) ? S_VERIFY : S_STDRAIN;
					cnt_q <= 3'd0;
				end
			end
			S_STDRAIN: begin
				if (q_valid && !q_ready) begin
					q_ready <= 1'b1;
				end else if (!q_valid) begin
					st_q <= S_IDLE;
					bank_lock_q <= 1'b0;
					status_q[`FPS_SR_READY] <= 1'b1;
					status_q[`FPS_SR_BANK_WRITE] <= 1'b0;
				end
			end
			default: st_q <= S_IDLE;
			endcase
			// Placed after the case so a set wins over a clear.
			if (lock_violation_in) begin
				status_q[`FPS_SR_LOCK_VIOL] <= 1'b1;
			end
		end
	end
endmodule

// ### testbench/fps_sequencer_asserts.sv
`timescale 1ns/10ps
module fps_sequencer_asserts #(
	parameter AW = 21
) (
	input wire core_clk,
	input wire nrst,
	input wire ce,
	input wire bus_we,
	input wire bus_re,
	input wire [AW-1:0] bus_addr,
	input wire [15:0] bus_data,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire arr_we,
	input wire [AW-1:0] arr_addr,
	input wire [15:0] arr_data,
	input wire arr_ok,
	input wire [15:0] arr_rdata,
	input wire [7:0] status_q,
	input wire status_mode_q,
	input wire bank_lock_q,
	input wire lock_violation_in
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	a_busy_bank_lock: assert property (!status_q[7] |-> bank_lock_q)
		else $error("bank not locked while busy");
	a_busy_status_mode: assert property (!status_q[7] |-> status_mode_q)
		else $error("no status mode while busy");
	a_read_gives_status: assert property (rd_valid && status_mode_q
		&& $past(status_mode_q) && $stable(status_q) |-> rd_data[7:0] == status_q)
		else $error("read did not return status");
	a_bank_write_busy: assert property (status_q[0] |-> !status_q[7])
		else $error("bank write bit set while idle");
	a_bank_write_ends: assert property ($rose(status_q[0]) |->
		##[1:1000] !status_q[0])
		else $error("program phase never ended");
	a_reset_status: assert property (disable iff (1'b0)
		!nrst && ce |=> status_q == 8'h80 && !status_mode_q)
		else $error("reset did not restore status");
	a_error_sticky: assert property ((!bus_we)[*5] ##0 status_q[1]
		|=> status_q[1])
		else $error("error bit cleared without a write");
	a_lock_viol_sets: assert property (lock_violation_in && ce
		|-> ##[1:2] status_q[1])
		else $error("lock violation not recorded");
	c_page_done: cover property ($fell(status_q[0]));
	c_prog_fail: cover property ($rose(status_q[4]));
	c_array_write: cover property (arr_we);
endmodule

bind fps_sequencer fps_sequencer_asserts #(.AW(AW)) fps_sequencer_asserts_i (
	.core_clk(core_clk), .nrst(nrst), .ce(ce), .bus_we(bus_we),
	.bus_re(bus_re), .bus_addr(bus_addr), .bus_data(bus_data),
	.rd_data(rd_data), .rd_valid(rd_valid), .arr_we(arr_we),
	.arr_addr(arr_addr), .arr_data(arr_data), .arr_ok(arr_ok),
	.arr_rdata(arr_rdata), .status_q(status_q),
	.status_mode_q(status_mode_q), .bank_lock_q(bank_lock_q),
	.lock_violation_in(lock_violation_in)
);

// ### testbench/fps_array_model.sv
`timescale 1ns/10ps
// Stand-in for the array: keeps programmed words, verify fails on demand.
module fps_array_model (
	// Clock
	input wire core_clk,
	// Programming port
	input wire arr_we,
	input wire [20:0] arr_addr,
	input wire [15:0] arr_data,
	output wire arr_ok,
	output wire [15:0] arr_rdata,
	// Fault injection
	input wire fail
);
	reg [15:0] mem [0:63];
	always @(posedge core_clk) begin
		if (arr_we) begin
			mem[arr_addr[5:0]] <= arr_data;
		end
	end
	assign arr_ok = !fail;
	assign arr_rdata = mem[arr_addr[5:0]];
endmodule

// ### testbench/factory_program_sequencer_bench.sv
`timescale 1ns/10ps
module factory_program_sequencer_bench;
	reg core_clk = 0;
	reg nrst = 0;
	reg ce = 1;
	reg bus_we = 0;
	reg bus_re = 0;
	reg [20:0] bus_addr = 0;
	reg [15:0] bus_data = 0;
	reg lock_violation_in = 0;
	reg fail = 0;
	wire [15:0] rd_data, arr_data, arr_rdata;
	wire [20:0] arr_addr;
	wire [7:0] status_q;
	wire rd_valid, arr_we, arr_ok, status_mode_q, bank_lock_q;
	reg [15:0] v;
	integer n_fail = 0;
	integer samples_checked = 0;
	integer cyc = 0;
	integer i, j;
	always #12.5 core_clk = ~core_clk;
	fps_sequencer #(.PROG_CYC(4)) fps_sequencer_i (.core_clk(core_clk),
		.nrst(nrst), .ce(ce), .bus_we(bus_we), .bus_re(bus_re),
		.bus_addr(bus_addr), .bus_data(bus_data), .rd_data(rd_data),
		.rd_valid(rd_valid), .arr_we(arr_we), .arr_addr(arr_addr),
		.arr_data(arr_data), .arr_ok(arr_ok), .arr_rdata(arr_rdata),
		.status_q(status_q), .status_mode_q(status_mode_q),
		.bank_lock_q(bank_lock_q), .lock_violation_in(lock_violation_in));
	fps_array_model fps_array_model_i (.core_clk(core_clk), .arr_we(arr_we),
		.arr_addr(arr_addr), .arr_data(arr_data), .arr_ok(arr_ok),
		.arr_rdata(arr_rdata), .fail(fail));
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("mismatch t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task rd;
		begin
			@(posedge core_clk);
			#2 bus_re = 1;
			repeat (4) @(posedge core_clk);
			#2 v = rd_data;
			bus_re = 0;
		end
	endtask
	// Each write is followed by a read (status in status mode, array data otherwise) before the next one.
	task wr(input [20:0] a, input [15:0] d);
		begin
			@(posedge core_clk);
			#2 bus_addr = a;
			bus_data = d;
			bus_we = 1;
			repeat (4) @(posedge core_clk);
			#2 bus_we = 0;
			bus_data = ~d;
			rd;
		end
	endtask
	task wbit(input integer b, input e);
		begin
			i = 0;
			while (status_q[b] !== e && i < 1200) begin
				@(posedge core_clk);
				#2 i = i + 1;
			end
			chk(status_q[b], e);
		end
	endtask
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			end_of_test;
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		#2 nrst = 1;
		chk(status_q, 8'h80);
		wr(21'h008003, 16'h0075);
		chk({status_mode_q, bank_lock_q}, 2'b11);
		wr(21'h008006, 16'h1111);
		chk(v[7], 1'b0);
		wr(21'h1fffff, 16'h2222);
		wr(21'h000000, 16'h3333);
		wr(21'h000000, 16'h4444);
		chk({v[7], v[0]}, 2'b01);
		wbit(0, 1'b0);
		for (j = 0; j < 4; j = j + 1)
			chk(fps_array_model_i.mem[4+j], 16'h1111 * (j + 1));
		wr(21'h010000, 16'h1234);
		fail = 1;
		for (j = 0; j < 4; j = j + 1)
			wr(21'h008008 + j, 16'h5555 + j);
		wbit(0, 1'b0);
		for (j = 0; j < 4; j = j + 1)
			chk(fps_array_model_i.mem[8+j], 16'h5555 + j);
		wr(21'h010000, 16'hffff);
		wbit(7, 1'b1);
		chk({status_mode_q, status_q[4]}, 2'b01);
		fail = 0;
		lock_violation_in = 1;
		@(posedge core_clk);
		#2 lock_violation_in = 0;
		wbit(1, 1'b1);
		wr(21'h000000, 16'h0050);
		chk(status_q, 8'h80);
		ce = 0;
		lock_violation_in = 1;
		repeat (2) @(posedge core_clk);
		#2 lock_violation_in = 0;
		ce = 1;
		chk(status_q, 8'h80);
		wr(21'h000005, 16'h0035);
		wr(21'h000010, 16'haaaa);
		wr(21'h000011, 16'hbbbb);
		wbit(7, 1'b1);
		chk(fps_array_model_i.mem[17], 16'hbbbb);
		chk(fps_array_model_i.mem[16], 16'haaaa);
		wr(21'h000007, 16'h0056);
		for (j = 0; j < 4; j = j + 1)
			wr(21'h000020 + j, 16'hc000 + j);
		wbit(7, 1'b1);
		for (j = 0; j < 4; j = j + 1)
			chk(fps_array_model_i.mem[32+j], 16'hc000 + j);
		wr(21'h000000, 16'h0030);
		wr(21'h007fff, 16'h00d0);
		for (j = 0; j < 6; j = j + 1)
			wr(j % 3 == 2 ? 21'h010000 : 21'h000028,
				j % 3 == 2 ? 16'hffff : 16'hdddd + j % 3);
		wbit(7, 1'b1);
		chk(fps_array_model_i.mem[40], 16'hdddd);
		chk(fps_array_model_i.mem[41], 16'hddde);
		wr(21'h000000, 16'h0075);
		for (j = 0; j < 4; j = j + 1)
			wr(21'h000030 + j, 16'h0f0f);
		@(posedge core_clk);
		#2 nrst = 0;
		repeat (2) @(posedge core_clk);
		#2 nrst = 1;
		chk({status_q, 6'h00, bank_lock_q, status_mode_q}, 16'h8000);
		end_of_test;
	end
endmodule
